/* design/gpr_bank.sv */
// Sixteen-word register bank held in internal RAM behind a context pointer
// ----------------------------------------------------------------------
// What this block does
// - Bank base is the context pointer, settable to any even address that keeps the whole bank inside RAM.
// - Bank lives only in internal RAM; illegal pointer values refused.
// - Any bit of any of the sixteen words can be tested or modified.
// - Word register n sits at pointer plus two times n.
// - Short addresses f0 to ff pick words 0 to 15 via pointer.
// - Word registers are not initialised at reset.
// - Only words 0 to 7 also offer byte access.
// - Byte write changes only the addressed byte.
// - Low byte of n at pointer plus 2n, high byte at 2n+1.
// - Byte halves are left undefined after reset.
// ----------------------------------------------------------------------
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "gpr_bank_map.svh"

module gpr_bank #(
   parameter int RAM_WORDS = `RAM_WORDS_DEF,
   parameter logic [15:0] RAM_BASE = `RAM_BASE_DEF
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU datapath request
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire gpr_bank_pkg::access_e cpu_access,
   input wire gpr_bank_pkg::bit_fn_e cpu_bit_fn,
   input wire logic [7:0] cpu_reg_addr,
   input wire logic [3:0] cpu_bit_sel,
   input wire logic [15:0] cpu_wdata,
   // CPU datapath answer
   output logic cpu_ack,
   output logic cpu_err,
   output logic [15:0] cpu_rdata,
   // Current bank base
   output logic [15:0] context_pointer
);
   import gpr_bank_pkg::*;

   localparam int AW = $clog2(RAM_WORDS);
   localparam int RAM_BYTES = 2 * RAM_WORDS;

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (RAM_WORDS < 16 || (2 ** AW) != RAM_WORDS) begin : g_bad_words
      $error("gpr_bank: RAM_WORDS must be a power of two of at least 16");
   end
   if (RAM_BASE[0] != 1'b0 || int'(RAM_BASE) + RAM_BYTES > 65536)
   begin : g_bad_base
      $error("gpr_bank: RAM_BASE must be even and the RAM fit 64 KiB");
   end

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   state_e state_r;
   state_e state_nxt;
   logic owner_apb_r;
   access_e acc_r;
   bit_fn_e fn_r;
   logic [3:0] bit_r;
   logic hi_r;
   logic err_r;
   logic [AW-1:0] ram_addr_r;
   logic [15:0] cp_r;
   logic cp_reject_r;
   logic cpu_err_seen_r;
   logic [15:0] cpu_rdata_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   logic [AW-1:0] ram_addr;
   logic ram_we;
   logic [1:0] ram_be;
   logic [15:0] ram_wdata;
   logic [15:0] ram_rdata;
   logic [15:0] alu_word;

   logic cpu_go;
   logic apb_go;
   logic cpu_addr_ok;
   logic [3:0] cpu_num;
   logic apb_gpr;
   logic apb_cp;
   logic apb_stat;
   logic cp_wr;
   logic cp_ok;
   logic stat_wr;

   // Word position of register n in the RAM array
   function automatic logic [AW-1:0] word_addr(input logic [15:0] cp,
                                               input logic [3:0] n);
      int off;
      off = (int'(cp) - int'(RAM_BASE)) / 2 + int'(n);
      return AW'(off);
   endfunction

   // ----------------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------------
   // Datapath wins over software when both request in the same idle cycle
   assign cpu_go = state_r == st_idle && cpu_req;
   assign apb_go = state_r == st_idle && !cpu_req && psel && penable;

   assign cpu_addr_ok = cpu_reg_addr[7:4] == `SHORT_ADDR_PAGE;
   // Byte mode folds two short addresses onto one word
   assign cpu_num = (cpu_access == acc_byte) ?
                    {1'b0, cpu_reg_addr[3:1]} : cpu_reg_addr[3:0];

   assign apb_gpr = apb_gpr_hit(paddr);
   assign apb_cp = paddr == `CP_ADDR;
   assign apb_stat = paddr == `STATUS_ADDR;
   assign cp_wr = apb_go && apb_cp && pwrite;
   assign cp_ok = cp_legal(pwdata[15:0], RAM_BASE, RAM_BYTES);
   assign stat_wr = apb_go && apb_stat && pwrite;

   // ----------------------------------------------------------------------
   // RAM port steering
   // ----------------------------------------------------------------------
   always_comb begin
      ram_addr = ram_addr_r;
      ram_we = 1'b0;
      ram_be = 2'b11;
      ram_wdata = alu_word;
      if (cpu_go && cpu_addr_ok) begin
         ram_addr = word_addr(cp_r, cpu_num);
         ram_we = cpu_write && cpu_access != acc_bit;
         if (cpu_access == acc_byte) begin
            ram_be = cpu_reg_addr[0] ? 2'b10 : 2'b01;
            ram_wdata = {cpu_wdata[7:0], cpu_wdata[7:0]};
         end else begin
            ram_wdata = cpu_wdata;
         end
      end else if (apb_go && apb_gpr) begin
         ram_addr = word_addr(cp_r, apb_gpr_num(paddr));
         ram_we = pwrite;
         ram_wdata = pwdata[15:0];
      end else if (state_r == st_read && acc_r == acc_bit &&
                   fn_r != bf_test) begin
         ram_we = 1'b1;
      end
   end

   gpr_ram #(
      .WORDS(RAM_WORDS),
      .AW(AW)
   ) u_ram (
      .clk(pclk),
      .addr(ram_addr),
      .we(ram_we),
      .be(ram_be),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   gpr_bit_alu u_alu (
      .word_in(ram_rdata),
      .bit_sel(bit_r),
      .fn(fn_r),
      .word_out(alu_word)
   );

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_idle: begin
            if (cpu_go) begin
               if (!cpu_addr_ok || ram_we) begin
                  state_nxt = st_done;
               end else begin
                  state_nxt = st_read;
               end
            end else if (apb_go) begin
               if (apb_gpr && !pwrite) begin
                  state_nxt = st_read;
               end else begin
                  state_nxt = st_done;
               end
            end
         end
         st_read: state_nxt = st_done;
         st_done: state_nxt = st_idle;
         default: state_nxt = st_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Request capture for the later cycles of a transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         owner_apb_r <= 1'b0;
         acc_r <= acc_word;
         fn_r <= bf_test;
         bit_r <= 4'h0;
         hi_r <= 1'b0;
         err_r <= 1'b0;
         ram_addr_r <= '0;
      end else if (cpu_go || apb_go) begin
         owner_apb_r <= apb_go;
         acc_r <= cpu_go ? cpu_access : acc_word;
         fn_r <= cpu_go ? cpu_bit_fn : bf_test;
         bit_r <= cpu_bit_sel;
         hi_r <= cpu_reg_addr[0];
         err_r <= cpu_go && !cpu_addr_ok;
         ram_addr_r <= ram_addr;
      end
   end

   // ----------------------------------------------------------------------
   // Context pointer and status
   // ----------------------------------------------------------------------
   // Only changed while idle, so no access ever sees a half-moved bank
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cp_r <= RAM_BASE;
      end else if (cp_wr && cp_ok) begin
         cp_r <= pwdata[15:0];
      end
   end

   // Sticky flags, write one to clear, a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cp_reject_r <= 1'b0;
      end else if (cp_wr && !cp_ok) begin
         cp_reject_r <= 1'b1;
      end else if (stat_wr && pwdata[`STAT_CP_REJECT_BIT]) begin
         cp_reject_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_err_seen_r <= 1'b0;
      end else if (cpu_go && !cpu_addr_ok) begin
         cpu_err_seen_r <= 1'b1;
      end else if (stat_wr && pwdata[`STAT_CPU_ERR_BIT]) begin
         cpu_err_seen_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Answers
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_rdata_r <= 16'h0000;
      end else if (state_r == st_read && !owner_apb_r) begin
         if (acc_r == acc_byte) begin
            cpu_rdata_r <= {8'h00, hi_r ? ram_rdata[15:8] : ram_rdata[7:0]};
         end else begin
            cpu_rdata_r <= ram_rdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (apb_go) begin
         pslverr_r <= !(apb_gpr || apb_cp || apb_stat) || (cp_wr && !cp_ok);
         prdata_r <= 32'h0000_0000;
         if (apb_cp && !pwrite) begin
            prdata_r <= {16'h0000, cp_r};
         end else if (apb_stat && !pwrite) begin
            prdata_r[`STAT_CP_REJECT_BIT] <= cp_reject_r;
            prdata_r[`STAT_CPU_ERR_BIT] <= cpu_err_seen_r;
         end
      end else if (state_r == st_read && owner_apb_r) begin
         prdata_r <= {16'h0000, ram_rdata};
      end
   end

   assign pready = state_r == st_done && owner_apb_r;
   assign pslverr = pready && pslverr_r;
   assign prdata = prdata_r;
   assign cpu_ack = state_r == st_done && !owner_apb_r;
   assign cpu_err = cpu_ack && err_r;
   assign cpu_rdata = cpu_rdata_r;
   assign context_pointer = cp_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   cp_inside_ram_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cp_legal(cp_r, RAM_BASE, RAM_BYTES))
      else $error("context pointer left internal RAM");
   cp_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cp_wr && cp_ok |=> cp_r == $past(pwdata[15:0]) ##1 $stable(cp_r))
      else $error("legal pointer write not taken");
   cp_refuse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cp_wr && !cp_ok |=> $stable(cp_r) && cp_reject_r && pslverr)
      else $error("illegal pointer write not refused");
   word_place_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cpu_go && cpu_addr_ok && cpu_access != acc_byte |->
      int'(ram_addr) * 2 + int'(RAM_BASE) ==
      int'(cp_r) + 2 * int'(cpu_reg_addr[3:0]))
      else $error("word register at wrong RAM address");
   short_page_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cpu_go && !cpu_addr_ok |-> !ram_we ##1 cpu_ack && cpu_err)
      else $error("short address outside page not rejected");
   byte_place_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cpu_go && cpu_addr_ok && cpu_access == acc_byte |->
      int'(ram_addr) * 2 + int'(RAM_BASE) + int'(cpu_reg_addr[0]) ==
      int'(cp_r) + int'(cpu_reg_addr[3:0]) &&
      int'(ram_addr) - (int'(cp_r) - int'(RAM_BASE)) / 2 < 8)
      else $error("byte register at wrong RAM address");
   byte_lane_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cpu_go && cpu_addr_ok && cpu_access == acc_byte && cpu_write |->
      ram_we && ram_be == (cpu_reg_addr[0] ? 2'b10 : 2'b01) &&
      ram_wdata == {2{cpu_wdata[7:0]}} ##1 cpu_ack)
      else $error("byte write touched the other byte");
   bit_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_r == st_read && acc_r == acc_bit && fn_r == bf_set |->
      ram_we && ram_wdata == (ram_rdata | (16'h0001 << bit_r)))
      else $error("bit set wrote a wrong word");
   bit_seq_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cpu_go && cpu_addr_ok && cpu_access == acc_bit |->
      !ram_we ##1 state_r == st_read ##1 cpu_ack && !cpu_err)
      else $error("bit access sequence broken");
   word_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      cpu_go && cpu_addr_ok && cpu_access == acc_word && cpu_write |->
      ram_we && ram_be == 2'b11 && ram_wdata == cpu_wdata ##1 cpu_ack)
      else $error("word write not both bytes in one cycle");
   word_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_r == st_read && !owner_apb_r && acc_r == acc_word |=>
      cpu_ack && cpu_rdata == $past(ram_rdata))
      else $error("word read did not return the whole word");

endmodule

`default_nettype wire

/* design/gpr_bank_map.svh */
// Offsets, field positions, reset values and limits of the register bank
`ifndef GPR_BANK_MAP_SVH
`define GPR_BANK_MAP_SVH

// ----------------------------------------------------------------------
// Word register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define GPR_WORD_0_IDX 8'h00
`define GPR_WORD_1_IDX 8'h02
`define GPR_WORD_2_IDX 8'h04
`define GPR_WORD_3_IDX 8'h06
`define GPR_WORD_4_IDX 8'h08
`define GPR_WORD_5_IDX 8'h0a
`define GPR_WORD_6_IDX 8'h0c
`define GPR_WORD_7_IDX 8'h0e
`define GPR_WORD_8_IDX 8'h10
`define GPR_WORD_9_IDX 8'h12
`define GPR_WORD_10_IDX 8'h14
`define GPR_WORD_11_IDX 8'h16
`define GPR_WORD_12_IDX 8'h18
`define GPR_WORD_13_IDX 8'h1a
`define GPR_WORD_14_IDX 8'h1c
`define GPR_WORD_15_IDX 8'h1e

// ----------------------------------------------------------------------
// Control and status registers
// ----------------------------------------------------------------------
`define CP_ADDR 8'h80
`define STATUS_ADDR 8'h84
`define STAT_CP_REJECT_BIT 0
`define STAT_CPU_ERR_BIT 1

// ----------------------------------------------------------------------
// Bank geometry and internal RAM defaults
// ----------------------------------------------------------------------
`define GPR_LAST_OFFSET 30
`define SHORT_ADDR_PAGE 4'hf
`define RAM_WORDS_DEF 1024
`define RAM_BASE_DEF 16'hf600

`endif

/* design/gpr_bank_pkg.sv */
// Types and shared helper functions of the register bank
`include "gpr_bank_map.svh"

package gpr_bank_pkg;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_read = 2'b01,
      st_done = 2'b10
   } state_e;

   typedef enum logic [1:0] {
      acc_word = 2'b00,
      acc_byte = 2'b01,
      acc_bit = 2'b10
   } access_e;

   typedef enum logic [1:0] {
      bf_test = 2'b00,
      bf_set = 2'b01,
      bf_clear = 2'b10,
      bf_toggle = 2'b11
   } bit_fn_e;

   // Pointer must be even and keep the whole bank inside the RAM
   function automatic logic cp_legal(input logic [15:0] cp,
                                     input logic [15:0] base,
                                     input int bytes);
      int off;
      off = int'(cp) - int'(base);
      return cp[0] == 1'b0 && off >= 0 && off + `GPR_LAST_OFFSET < bytes;
   endfunction

   function automatic logic apb_gpr_hit(input logic [7:0] a);
      logic [7:0] idx;
      idx = {2'b00, a[7:2]};
      return a[1:0] == 2'b00 && idx[0] == 1'b0 &&
             idx >= `GPR_WORD_0_IDX && idx <= `GPR_WORD_15_IDX;
   endfunction

   function automatic logic [3:0] apb_gpr_num(input logic [7:0] a);
      logic [7:0] idx;
      idx = {2'b00, a[7:2]} - `GPR_WORD_0_IDX;
      return idx[4:1];
   endfunction

endpackage

/* design/gpr_ram.sv */
// Internal RAM word array with byte lane writes and registered read
`timescale 1ns/10ps
`default_nettype none
`include "gpr_bank_map.svh"

module gpr_ram #(
   parameter int WORDS = `RAM_WORDS_DEF,
   parameter int AW = $clog2(`RAM_WORDS_DEF)
) (
   // Clock
   input wire logic clk,
   // Access
   input wire logic [AW-1:0] addr,
   input wire logic we,
   input wire logic [1:0] be,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);

   // No reset: contents stay undefined until written
   logic [15:0] mem [WORDS];

   if ((2 ** AW) != WORDS) begin : g_bad_size
      $error("gpr_ram: WORDS must equal 2**AW");
   end

   always_ff @(posedge clk) begin
      if (we && be[0]) begin
         mem[addr][7:0] <= wdata[7:0];
      end
      if (we && be[1]) begin
         mem[addr][15:8] <= wdata[15:8];
      end
      rdata <= mem[addr];
   end

endmodule

`default_nettype wire

/* design/gpr_bit_alu.sv */
// Single bit test, set, clear and toggle on one register word
`timescale 1ns/10ps
`default_nettype none

module gpr_bit_alu (
   // Operand
   input wire logic [15:0] word_in,
   input wire logic [3:0] bit_sel,
   input wire gpr_bank_pkg::bit_fn_e fn,
   // Result
   output logic [15:0] word_out
);
   import gpr_bank_pkg::*;

   logic [15:0] mask;

   assign mask = 16'h0001 << bit_sel;

   always_comb begin
      case (fn)
         bf_set: word_out = word_in | mask;
         bf_clear: word_out = word_in & ~mask;
         bf_toggle: word_out = word_in ^ mask;
         default: word_out = word_in;
      endcase
   end

endmodule

`default_nettype wire

/* testbench/cpu_datapath_model.sv */
// Behavioural model of the CPU datapath that requests register accesses
`timescale 1ns/10ps
`default_nettype none

module cpu_datapath_model (
   // Clock
   input wire logic pclk,
   // Request
   output logic cpu_req,
   output logic cpu_write,
   output var gpr_bank_pkg::access_e cpu_access,
   output var gpr_bank_pkg::bit_fn_e cpu_bit_fn,
   output logic [7:0] cpu_reg_addr,
   output logic [3:0] cpu_bit_sel,
   output logic [15:0] cpu_wdata,
   // Answer
   input wire logic cpu_ack,
   input wire logic cpu_err,
   input wire logic [15:0] cpu_rdata
);
   import gpr_bank_pkg::*;

   initial begin
      cpu_req = 1'b0;
      cpu_write = 1'b0;
      cpu_access = acc_word;
      cpu_bit_fn = bf_test;
      cpu_reg_addr = 8'h00;
      cpu_bit_sel = 4'h0;
      cpu_wdata = 16'h0000;
   end

   // Held until ack; afterwards address, bit select and write data show the inverse, never stale data
   task automatic access(input access_e acc, input bit_fn_e fn,
                         input logic wr, input logic [7:0] a,
                         input logic [3:0] b, input logic [15:0] wd,
                         output logic [15:0] rd, output logic err);
      @(posedge pclk);
      cpu_req <= 1'b1;
      cpu_write <= wr;
      cpu_access <= acc;
      cpu_bit_fn <= fn;
      cpu_reg_addr <= a;
      cpu_bit_sel <= b;
      cpu_wdata <= wd;
      // Waits for the answer; only the bench's cycle ceiling ends a hang
      do @(posedge pclk); while (cpu_ack !== 1'b1);
      rd = cpu_rdata;
      err = cpu_err;
      cpu_req <= 1'b0;
      cpu_reg_addr <= ~a;
      cpu_bit_sel <= ~b;
      cpu_wdata <= ~wd;
   endtask
endmodule
`default_nettype wire

/* testbench/gpr_bank_tb.sv */
// Self-checking bench of the register bank behind the context pointer
`timescale 1ns/10ps
`default_nettype none
`include "gpr_bank_map.svh"

module gpr_bank_tb;
   import gpr_bank_pkg::*;
   localparam int RAM_WORDS = 64;
   localparam logic [15:0] RAM_BASE = 16'hf600;
   localparam logic [15:0] CP_TOP = RAM_BASE + 16'(2 * RAM_WORDS - 32);
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, cpu_req, cpu_write, cpu_ack, cpu_err;
   access_e cpu_access;
   bit_fn_e cpu_bit_fn;
   logic [7:0] cpu_reg_addr;
   logic [3:0] cpu_bit_sel;
   logic [15:0] cpu_wdata, cpu_rdata, context_pointer;
   logic [15:0] mem [16];
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   gpr_bank #(.RAM_WORDS(RAM_WORDS), .RAM_BASE(RAM_BASE)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
      .cpu_write(cpu_write), .cpu_access(cpu_access),
      .cpu_bit_fn(cpu_bit_fn), .cpu_reg_addr(cpu_reg_addr),
      .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack),
      .cpu_err(cpu_err), .cpu_rdata(cpu_rdata),
      .context_pointer(context_pointer));

   cpu_datapath_model u_cpu (
      .pclk(pclk), .cpu_req(cpu_req), .cpu_write(cpu_write),
      .cpu_access(cpu_access), .cpu_bit_fn(cpu_bit_fn),
      .cpu_reg_addr(cpu_reg_addr), .cpu_bit_sel(cpu_bit_sel),
      .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_err(cpu_err),
      .cpu_rdata(cpu_rdata));

   always #50 pclk = ~pclk;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~wd;
   endtask

   task automatic apb_wr(input logic [7:0] a, input logic [15:0] d,
                         input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, {16'h0000, d}, rd, err);
      check("write error", {31'h0, err}, {31'h0, exp_err});
   endtask

   task automatic apb_rd(input logic [7:0] a, input logic [15:0] exp,
                         input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check("read error", {31'h0, err}, {31'h0, exp_err});
      check("read data", rd, {16'h0000, exp});
   endtask

   task automatic cpu_op(input access_e acc, input bit_fn_e fn,
                         input logic wr, input logic [7:0] a,
                         input logic [3:0] b, input logic [15:0] wd,
                         input logic [15:0] exp, input logic exp_err);
      logic [15:0] rd;
      logic err;
      u_cpu.access(acc, fn, wr, a, b, wd, rd, err);
      check("cpu error", {31'h0, err}, {31'h0, exp_err});
      if (!wr || acc == acc_bit)
         check("cpu data", {16'h0, rd}, {16'h0, exp});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_words;
      for (int n = 0; n < 16; n++) begin
         mem[n] = (16'(n + 1) * 16'h1357) ^ 16'h5a0f;
         apb_wr(8'(8 * n), mem[n], 1'b0);
      end
      for (int n = 0; n < 16; n++) begin
         cpu_op(acc_word, bf_test, 1'b0, {`SHORT_ADDR_PAGE, 4'(n)}, 4'h0,
                16'h0, mem[n], 1'b0);
         mem[n] = ~mem[n];
         cpu_op(acc_word, bf_test, 1'b1, {`SHORT_ADDR_PAGE, 4'(n)}, 4'h0,
                mem[n], 16'h0, 1'b0);
         apb_rd(8'(8 * n), mem[n], 1'b0);
      end
   endtask

   // Every byte of words 0 to 7, low and high half in turn
   task automatic t_bytes;
      logic [7:0] d;
      for (int k = 0; k < 16; k++) begin
         d = 8'(k * 17) ^ 8'h3c;
         if (k % 2 == 1)
            mem[k / 2][15:8] = d;
         else
            mem[k / 2][7:0] = d;
         cpu_op(acc_byte, bf_test, 1'b1, {`SHORT_ADDR_PAGE, 4'(k)}, 4'h0,
                {8'h00, d}, 16'h0, 1'b0);
         cpu_op(acc_byte, bf_test, 1'b0, {`SHORT_ADDR_PAGE, 4'(k)}, 4'h0,
                16'h0, {8'h00, d}, 1'b0);
         apb_rd(8'(8 * (k / 2)), mem[k / 2], 1'b0);
      end
   endtask

   task automatic t_bits;
      logic [15:0] old;
      logic [15:0] m;
      for (int i = 0; i < 4; i++) begin
         old = mem[9];
         m = 16'h0001 << (i * 5);
         case (bit_fn_e'(i))
            bf_set: mem[9] = old | m;
            bf_clear: mem[9] = old & ~m;
            bf_toggle: mem[9] = old ^ m;
            default: mem[9] = old;
         endcase
         cpu_op(acc_bit, bit_fn_e'(i), 1'b0, 8'hf9, 4'(i * 5), 16'h0,
                old, 1'b0);
         apb_rd(8'h48, mem[9], 1'b0);
      end
   endtask

   task automatic t_pointer;
      logic [15:0] bad [3];
      bad = '{RAM_BASE + 16'h1, RAM_BASE - 16'h2, CP_TOP + 16'h2};
      apb_wr(`CP_ADDR, RAM_BASE + 16'h2, 1'b0);
      apb_rd(`CP_ADDR, RAM_BASE + 16'h2, 1'b0);
      check("context pointer", {16'h0, context_pointer},
            {16'h0, RAM_BASE + 16'h2});
      cpu_op(acc_word, bf_test, 1'b0, 8'hf0, 4'h0, 16'h0, mem[1],
             1'b0);
      cpu_op(acc_word, bf_test, 1'b0, 8'hfe, 4'h0, 16'h0, mem[15],
             1'b0);
      apb_rd(8'h00, mem[1], 1'b0);
      apb_wr(`CP_ADDR, CP_TOP, 1'b0);
      apb_rd(`CP_ADDR, CP_TOP, 1'b0);
      foreach (bad[i]) begin
         apb_wr(`CP_ADDR, bad[i], 1'b1);
         apb_rd(`CP_ADDR, CP_TOP, 1'b0);
         check("context pointer", {16'h0, context_pointer},
               {16'h0, CP_TOP});
         apb_rd(`STATUS_ADDR, 16'h1 << `STAT_CP_REJECT_BIT, 1'b0);
         apb_wr(`STATUS_ADDR, 16'h1 << `STAT_CP_REJECT_BIT, 1'b0);
         apb_rd(`STATUS_ADDR, 16'h0000, 1'b0);
      end
      apb_wr(`CP_ADDR, RAM_BASE, 1'b0);
   endtask

   task automatic t_errors;
      cpu_op(acc_word, bf_test, 1'b1, 8'he0, 4'h0, 16'hdead, 16'h0,
             1'b1);
      apb_rd(`STATUS_ADDR, 16'h1 << `STAT_CPU_ERR_BIT, 1'b0);
      apb_wr(`STATUS_ADDR, 16'h1 << `STAT_CPU_ERR_BIT, 1'b0);
      apb_rd(`STATUS_ADDR, 16'h0000, 1'b0);
      apb_rd(8'h00, mem[0], 1'b0);
      apb_rd(8'h04, 16'h0000, 1'b1);
      apb_wr(8'h88, 16'hffff, 1'b1);
      apb_rd(`CP_ADDR, RAM_BASE, 1'b0);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb_rd(`CP_ADDR, RAM_BASE, 1'b0);
      check("context pointer", {16'h0, context_pointer},
            {16'h0, RAM_BASE});
      apb_rd(`STATUS_ADDR, 16'h0000, 1'b0);
      // Nothing written yet, so the bank must still read unknown
      apb_rd(8'h00, 16'hxxxx, 1'b0);
      cpu_op(acc_byte, bf_test, 1'b0, 8'hf1, 4'h0, 16'h0, 16'h00xx,
             1'b0);
      t_words();
      t_bytes();
      t_bits();
      t_pointer();
      t_errors();
      end_sim();
   end
endmodule
`default_nettype wire
